// [src/itvl_pkg.sv]
// Package of constants for the internal trap vector logic
`default_nettype none
package itvl_pkg;
    localparam int WORD_W = 16;
    localparam int CODE_W = 4;
    localparam int SRC_N = 11;
    localparam logic [3:0] BIT_MON = 4'h1;
    localparam logic [3:0] BIT_PROT = 4'h2;
    localparam logic [3:0] BIT_PAGE = 4'h3;
    localparam logic [3:0] BIT_ILL = 4'h4;
    localparam logic [3:0] BIT_ERRI = 4'h5;
    localparam logic [3:0] BIT_PRIV = 4'h6;
    localparam logic [3:0] BIT_IOERR = 4'h7;
    localparam logic [3:0] BIT_PAR = 4'h8;
    localparam logic [3:0] BIT_MOR = 4'h9;
    localparam logic [3:0] BIT_POW = 4'hA;
    localparam logic [3:0] LEVEL_TRAP = 4'hE;
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [15:0] ENABLE_MASK = 16'h07FE;
    localparam logic [3:0] CODE_RESET = 4'h0;
endpackage
`default_nettype wire

// [src/itvl_encoder.sv]
// Priority encoder from pending sources to cause code
`default_nettype none
module itvl_encoder (
    input wire logic [10:0] pending,
    output logic [3:0] code,
    output logic any
);
    always_comb begin
        code = itvl_pkg::CODE_RESET;
        if (pending[itvl_pkg::BIT_POW]) begin
            code = itvl_pkg::BIT_POW;
        end else begin
            for (int i = 1; i < 10; i++) begin
                if (pending[i]) begin
                    code = 4'(i);
                end
            end
        end
    end
    assign any = |pending[10:1];
endmodule // itvl_encoder
`default_nettype wire

// [src/itvl_sync.sv]
// Two-stage synchroniser for asynchronous inputs
`default_nettype none
module itvl_sync (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    logic meta_r;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_r <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule // itvl_sync
`default_nettype wire

// [src/itvl_top.sv]
// Internal trap detection, masking, encoding and level-14 request
`default_nettype none
module itvl_top (
    input wire logic ref_clk,
    input wire logic rst,
    // Register access from microprogram
    input wire logic enableWrite,
    input wire logic [15:0] writeData,
    input wire logic enableRead,
    input wire logic codeRead,
    output logic [15:0] readData,
    // CPU state
    input wire logic interruptsOn,
    input wire logic pagingOn,
    input wire logic instrDone,
    input wire logic fetchCycle,
    // Event strobes from the CPU
    input wire logic monitorCall,
    input wire logic [15:0] supervisorCallInstr,
    input wire logic protectViolation,
    input wire logic ringViolation,
    input wire logic [15:0] pagingInfo,
    input wire logic pageFault,
    input wire logic unimplementedOp,
    input wire logic privilegedAttempt,
    input wire logic errorIndicator,
    input wire logic ioTimeout,
    input wire logic parityError,
    input wire logic nonExistentMem,
    input wire logic [23:0] memAddress,
    input wire logic [15:0] memErrorInfo,
    input wire logic powerFailPin,
    // Results
    output logic levelRequest,
    output logic abortMicro,
    output logic holdPc,
    output logic tempLoad,
    output logic [15:0] tempValue,
    output logic [15:0] pagingStatus,
    output logic [15:0] errorAddressLow,
    output logic [15:0] errorStatusInfo
);
    logic [15:0] enable_r;
    logic [10:0] detect_r;
    logic [10:0] detect_nxt;
    logic [3:0] code_r;
    logic locked_r;
    logic [10:0] rawSrc;
    logic [10:0] pending;
    logic [3:0] encCode;
    logic encAny;
    logic powerFail;
    logic capture;
    logic immediateSrc;
    logic [10:0] gateMask;

    itvl_sync u_pow (
        .ref_clk(ref_clk),
        .rst(rst),
        .din(powerFailPin),
        .dout(powerFail)
    );

    always_comb begin
        rawSrc = '0;
        rawSrc[itvl_pkg::BIT_MON] = monitorCall;
        rawSrc[itvl_pkg::BIT_PROT] = (protectViolation | ringViolation) & pagingOn;
        rawSrc[itvl_pkg::BIT_PAGE] = pageFault & pagingOn;
        rawSrc[itvl_pkg::BIT_ILL] = unimplementedOp;
        rawSrc[itvl_pkg::BIT_ERRI] = errorIndicator;
        rawSrc[itvl_pkg::BIT_PRIV] = privilegedAttempt & pagingOn;
        rawSrc[itvl_pkg::BIT_IOERR] = ioTimeout;
        rawSrc[itvl_pkg::BIT_PAR] = parityError;
        rawSrc[itvl_pkg::BIT_MOR] = nonExistentMem;
        rawSrc[itvl_pkg::BIT_POW] = powerFail;
    end

    // immediate sources always eligible; others wait for instruction end
    always_comb begin
        gateMask = instrDone ? '1 : '0;
        gateMask[itvl_pkg::BIT_PROT] = 1'b1;
        gateMask[itvl_pkg::BIT_PAGE] = 1'b1;
        gateMask[itvl_pkg::BIT_ILL] = 1'b1;
    end

    // enable AND detect; interrupt system on
    assign pending = detect_r & enable_r[10:0] & gateMask & {11{interruptsOn}};

    itvl_encoder u_enc (
        .pending(pending),
        .code(encCode),
        .any(encAny)
    );

    // capture only when unlocked; nothing pending, no capture
    assign capture = encAny & ~locked_r;
    assign immediateSrc = capture & (encCode == itvl_pkg::BIT_PROT || encCode == itvl_pkg::BIT_PAGE ||
        encCode == itvl_pkg::BIT_ILL);

    // enable changes by software only; unassigned bits kept zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            enable_r <= itvl_pkg::ENABLE_RESET;
        end else if (enableWrite) begin
            enable_r <= writeData & itvl_pkg::ENABLE_MASK;
        end
    end

    // set detect bits; clear captured bit, set wins
    always_comb begin
        detect_nxt = detect_r;
        if (capture) begin
            detect_nxt[encCode] = 1'b0;
        end
        detect_nxt = detect_nxt | rawSrc;
        detect_nxt[0] = 1'b0;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            detect_r <= '0;
        end else begin
            detect_r <= detect_nxt;
        end
    end

    // read clears code; lock until read
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            code_r <= itvl_pkg::CODE_RESET;
            locked_r <= 1'b0;
        end else if (capture) begin
            code_r <= encCode;
            locked_r <= 1'b1;
        end else if (codeRead) begin
            code_r <= itvl_pkg::CODE_RESET;
            locked_r <= 1'b0;
        end
    end

    // code in low bits, rest zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            readData <= '0;
        end else if (codeRead) begin
            readData <= {12'h000, code_r};
        end else if (enableRead) begin
            readData <= enable_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            levelRequest <= 1'b0;
        end else begin
            levelRequest <= capture;
        end
    end

    // abort; hold PC on fetch fault
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            abortMicro <= 1'b0;
            holdPc <= 1'b0;
        end else begin
            abortMicro <= immediateSrc;
            holdPc <= capture & fetchCycle &
                (encCode == itvl_pkg::BIT_PROT || encCode == itvl_pkg::BIT_PAGE);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tempLoad <= 1'b0;
            tempValue <= '0;
        end else begin
            tempLoad <= monitorCall;
            if (monitorCall) begin
                tempValue <= {{8{supervisorCallInstr[7]}}, supervisorCallInstr[7:0]};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pagingStatus <= '0;
        end else if (rawSrc[itvl_pkg::BIT_PROT] | rawSrc[itvl_pkg::BIT_PAGE]) begin
            pagingStatus <= pagingInfo;
        end
    end

    // parity capture; out of range capture
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            errorAddressLow <= '0;
            errorStatusInfo <= '0;
        end else if (parityError | nonExistentMem) begin
            errorAddressLow <= memAddress[15:0];
            errorStatusInfo <= memErrorInfo;
        end
    end

    property p_lock;
        @(posedge ref_clk) disable iff (rst)
        locked_r && !codeRead |=> $stable(code_r);
    endproperty
    a_lock: assert property (p_lock) else $error("code changed while locked");

    property p_req;
        @(posedge ref_clk) disable iff (rst)
        capture |=> levelRequest && code_r == $past(encCode);
    endproperty
    a_req: assert property (p_req) else $error("no request on capture");

    property p_noreq;
        @(posedge ref_clk) disable iff (rst)
        pending == 11'h000 |=> !levelRequest;
    endproperty
    a_noreq: assert property (p_noreq) else $error("request with nothing pending");

    property p_pow;
        @(posedge ref_clk) disable iff (rst)
        pending[10] |-> encCode == 4'hA;
    endproperty
    a_pow: assert property (p_pow) else $error("power fail lost priority");

    property p_range;
        @(posedge ref_clk) disable iff (rst)
        code_r <= 4'hA;
    endproperty
    a_range: assert property (p_range) else $error("code out of range");

    property p_off;
        @(posedge ref_clk) disable iff (rst)
        !interruptsOn |=> !levelRequest;
    endproperty
    a_off: assert property (p_off) else $error("trap taken while off");

    property p_read;
        @(posedge ref_clk) disable iff (rst)
        codeRead && !capture |=> code_r == 4'h0 && readData[15:4] == 12'h000;
    endproperty
    a_read: assert property (p_read) else $error("read did not clear code");

    property p_enable;
        @(posedge ref_clk) disable iff (rst)
        !enableWrite |=> $stable(enable_r);
    endproperty
    a_enable: assert property (p_enable) else $error("enable changed by hardware");

    property p_sext;
        @(posedge ref_clk) disable iff (rst)
        monitorCall |=> tempValue[15:8] == {8{tempValue[7]}};
    endproperty
    a_sext: assert property (p_sext) else $error("bad sign extension");

    sequence s_capture;
        capture && !rawSrc[encCode];
    endsequence

    property p_clear;
        @(posedge ref_clk) disable iff (rst)
        s_capture |=> !detect_r[$past(encCode)];
    endproperty
    a_clear: assert property (p_clear) else $error("detect bit not cleared");

    property p_abort;
        @(posedge ref_clk) disable iff (rst)
        capture && encCode == itvl_pkg::BIT_PAGE |=> abortMicro;
    endproperty
    a_abort: assert property (p_abort) else $error("page fault did not abort");
endmodule // itvl_top
`default_nettype wire

// [tb/itvl_cpu_model.sv]
// Sequencer model: answers each level-14 request with a code read
`default_nettype none
module itvl_cpu_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic levelRequest,
    input wire logic [7:0] readDelay,
    output logic codeRead
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] LEVEL_ENABLE = 16'h4000;
    int waitCnt = -1;
    always @(negedge ref_clk) begin
        if (rst) begin
            codeRead <= 1'b0;
            waitCnt <= -1;
        end else if (levelRequest === 1'b1 && LEVEL_ENABLE[14]) begin
            codeRead <= 1'b0;
            waitCnt <= readDelay;
        end else begin
            codeRead <= (waitCnt == 0);
            waitCnt <= (waitCnt > 0) ? waitCnt - 1 : -1;
        end
    end
endmodule // itvl_cpu_model
`default_nettype wire

// [tb/internal_trap_vector_logic_tb.sv]
// Self-checking bench for the internal trap vector logic
`default_nettype none
module internal_trap_vector_logic_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic enableWrite = 1'b0, enableRead = 1'b0, codeRead, interruptsOn = 1'b1;
    logic pagingOn = 1'b1, instrDone = 1'b1, fetchCycle = 1'b1;
    logic [15:0] writeData = 16'h0000, readData, tempValue, pagingStatus;
    logic [15:0] errorAddressLow, errorStatusInfo;
    logic levelRequest, abortMicro, holdPc, tempLoad;
    logic [10:0] src = 11'h000;
    logic [7:0] readDelay = 8'h02;
    logic [15:0] nReq = 16'h0000, tempSeen = 16'h0000;
    logic [15:0] nAbort = 16'h0000, nHold = 16'h0000, a0, h0;
    int n_fail = 0, n_compared = 0;
    logic [11:0] rows [10] = '{12'h100, 12'h211, 12'h311, 12'h410, 12'h500,
                               12'h600, 12'h700, 12'h800, 12'h900, 12'hA00};
    itvl_top DUT (.ref_clk, .rst, .enableWrite, .writeData, .enableRead, .codeRead,
        .readData, .interruptsOn, .pagingOn, .instrDone, .fetchCycle,
        .monitorCall(src[1]), .supervisorCallInstr(16'h1285), .protectViolation(src[2]),
        .ringViolation(src[0]), .pagingInfo(16'h1234), .pageFault(src[3]),
        .unimplementedOp(src[4]), .privilegedAttempt(src[6]), .errorIndicator(src[5]),
        .ioTimeout(src[7]), .parityError(src[8]), .nonExistentMem(src[9]),
        .memAddress(24'hAB_CDEF), .memErrorInfo(16'h5A5A), .powerFailPin(src[10]),
        .levelRequest, .abortMicro, .holdPc, .tempLoad, .tempValue, .pagingStatus,
        .errorAddressLow, .errorStatusInfo);
    itvl_cpu_model partner (.ref_clk, .rst, .levelRequest, .readDelay, .codeRead);
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (levelRequest === 1'b1)
            nReq <= nReq + 16'h0001;
        if (abortMicro === 1'b1)
            nAbort <= nAbort + 16'h0001;
        if (holdPc === 1'b1)
            nHold <= nHold + 16'h0001;
        if (tempLoad === 1'b1)
            tempSeen <= tempValue;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic pulse(input logic [3:0] b);
        @(negedge ref_clk);
        src[b] = 1'b1;
        @(negedge ref_clk);
        src[b] = 1'b0;
    endtask
    task automatic waitRead(input logic [3:0] exp);
        int i;
        for (i = 0; i < 60; i++) begin
            @(posedge ref_clk);
            if (codeRead === 1'b1)
                break;
        end
        if (i == 60) begin
            n_fail++;
            give_verdict();
        end else begin
            @(negedge ref_clk);
            check(readData, {12'h000, exp});
        end
    endtask
    task automatic quiet(input int n);
        logic [15:0] c0;
        c0 = nReq;
        repeat (n) @(negedge ref_clk);
        check(nReq, c0);
    endtask
    task automatic wrEnable(input logic [15:0] d);
        @(negedge ref_clk);
        enableWrite = 1'b1;
        writeData = d;
        @(negedge ref_clk);
        enableWrite = 1'b0;
    endtask
    task automatic rdEnable(input logic [15:0] exp);
        @(negedge ref_clk);
        enableRead = 1'b1;
        @(negedge ref_clk);
        enableRead = 1'b0;
        check(readData, exp);
    endtask
    initial begin
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        rdEnable(16'h0000);
        wrEnable(16'hFFFF);
        rdEnable(16'h07FE);
        $display("register test done");
        foreach (rows[k]) begin
            a0 = nAbort;
            h0 = nHold;
            pulse(rows[k][11:8]);
            waitRead(rows[k][11:8]);
            check(nAbort - a0, {15'h0000, rows[k][4]});
            check(nHold - h0, {15'h0000, rows[k][0]});
            $display("row %0d done", k);
        end
        check(nReq, 16'h000A);
        check(tempSeen, 16'hFF85);
        check(pagingStatus, 16'h1234);
        check(errorAddressLow, 16'hCDEF);
        check(errorStatusInfo, 16'h5A5A);
        rdEnable(16'h07FE);
        interruptsOn = 1'b0;
        pulse(4'h3);
        quiet(8);
        interruptsOn = 1'b1;
        waitRead(4'h3);
        $display("interrupt-off test done");
        instrDone = 1'b0;
        pulse(4'h7);
        quiet(8);
        instrDone = 1'b1;
        waitRead(4'h7);
        $display("instruction-end test done");
        instrDone = 1'b0;
        pulse(4'h8);
        pulse(4'hA);
        quiet(8);
        instrDone = 1'b1;
        waitRead(4'hA);
        waitRead(4'h8);
        quiet(12);
        $display("power fail test done");
        readDelay = 8'h14;
        pulse(4'h3);
        pulse(4'h4);
        quiet(10);
        waitRead(4'h3);
        readDelay = 8'h02;
        waitRead(4'h4);
        $display("lock test done");
        fetchCycle = 1'b0;
        a0 = nAbort;
        h0 = nHold;
        pulse(4'h0);
        waitRead(4'h2);
        check(nAbort - a0, 16'h0001);
        check(nHold - h0, 16'h0000);
        fetchCycle = 1'b1;
        $display("ring and non-fetch test done");
        pagingOn = 1'b0;
        pulse(4'h2);
        quiet(8);
        pagingOn = 1'b1;
        wrEnable(16'h0000);
        pulse(4'h5);
        quiet(8);
        $display("masked test done");
        instrDone = 1'b0;
        wrEnable(16'hFFFF);
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        instrDone = 1'b1;
        rdEnable(16'h0000);
        wrEnable(16'h07FE);
        quiet(8);
        $display("mid-run reset test done");
        give_verdict();
    end
endmodule // internal_trap_vector_logic_tb
`default_nettype wire
